// ===== mevm_pkg.sv
package mevm_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] EVENT_MGR_A_BASE = 16'h7400;
  localparam logic [15:0] EVENT_MGR_B_BASE = 16'h7500;
  localparam logic [7:0]  OFF_TIMER2       = 8'h10;
  localparam logic [7:0]  OFF_CNT          = 8'h00;
  localparam logic [7:0]  OFF_CMP          = 8'h04;
  localparam logic [7:0]  OFF_PRD          = 8'h08;
  localparam logic [7:0]  OFF_CON          = 8'h0c;
  localparam logic [7:0]  OFF_COMCON       = 8'h20;
  localparam logic [7:0]  OFF_ACTION_CONTROL_REG         = 8'h24;
  localparam logic [7:0]  OFF_DBAND        = 8'h28;
  localparam logic [7:0]  OFF_FCMP1        = 8'h2c;
  localparam logic [7:0]  OFF_CAPCON       = 8'h38;
  localparam logic [7:0]  OFF_CAPFIFO      = 8'h3c;
  localparam logic [7:0]  OFF_CAPDATA1     = 8'h40;
  localparam logic [7:0]  OFF_FLAGS        = 8'h4c;
  localparam logic [7:0]  OFF_MASK         = 8'h50;
  localparam logic [7:0]  OFF_SYSTEM_CONTROL_REG2        = 8'h54;
  localparam logic [7:0]  OFF_STEP         = 8'h04;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TCON_MODE_LSB    = 0;
  localparam int TCON_ENABLE_BIT  = 2;
  localparam int TCON_EXTCLK_BIT  = 3;
  localparam int TCON_PRESC_LSB   = 4;
  localparam int TCON_SYNC_BIT    = 7;
  localparam int COMCON_EN_BIT    = 0;
  localparam int COMCON_DB_LSB    = 1;
  localparam int COMCON_PDP_BIT   = 8;
  localparam int CAPCON_TSEL_BIT  = 6;
  localparam int CAPCON_QEP_BIT   = 7;
  localparam int CAPCON_EN_LSB    = 8;
  localparam int FLAG_CAP_LSB     = 8;
  localparam int SYSTEM_CONTROL_REG2_QUAL_BIT   = 6;
  localparam int QUAL_PDP_IDX     = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          DB_MIN_NS     = 25;
  localparam logic [7:0]  DB_MIN_CYC    = 8'((DB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0]  QUAL_SHORT    = 4'h6;
  localparam logic [3:0]  QUAL_LONG     = 4'hc;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TM_STOP = 2'b00, TM_UP = 2'b01, TM_UPDOWN = 2'b10, TM_DIR = 2'b11} mevm_tmode_t;
  typedef enum logic [1:0] {EDGE_NONE = 2'b00, EDGE_RISE = 2'b01, EDGE_FALL = 2'b10, EDGE_BOTH = 2'b11} mevm_edge_t;

  typedef struct packed {
    logic       external_timer_clock_pin;
    logic       count_direction_pin;
    logic       power_protect_pin;
    logic [2:0] capture_input_pin;
    logic [1:0] external_interrupt_pins;
    logic       conversion_start_pin;
  } mevm_pins_t;

  typedef struct packed {
    logic [5:0] cmp_level;
    logic [5:0] cmp_oe;
    logic [1:0] timer_pwm_output;
    logic [1:0] timer_oe;
  } mevm_pwm_t;

  typedef struct packed {
    logic [1:0][15:0]      cnt;
    logic [1:0][15:0]      cmp;
    logic [1:0][15:0]      cmp_sh;
    logic [1:0][15:0]      prd;
    logic [1:0][15:0]      prd_sh;
    logic [1:0][15:0]      con;
    logic [1:0]            down;
    logic [1:0][6:0]       psc;
    logic                  ext_prev;
    logic [2:0][15:0]      fcmp;
    logic [2:0][15:0]      fcmp_sh;
    logic [15:0]           comcon;
    logic [15:0]           action_control_reg;
    logic [15:0]           action_control_reg_sh;
    logic [15:0]           capcon;
    logic [15:0]           mask;
    logic [15:0]           flags;
    logic [7:0]            dband;
    logic                  qual_long;
    logic [2:0][7:0]       db_cnt;
    logic [2:0]            raw_prev;
    logic [5:0]            pwm_level;
    logic [1:0]            t_level;
    logic [6:0]            sync1;
    logic [6:0]            sync2;
    logic [6:0]            qual;
    logic [6:0][3:0]       qcnt;
    logic [2:0]            cap_prev;
    logic [2:0][1:0][15:0] fifo;
    logic [2:0][1:0]       fcount;
    logic [31:0]           prdata;
  } mevm_state_t;

  localparam mevm_state_t MEVM_STATE_RESET = '0;

endpackage

// ===== mevm_event_manager.sv
`timescale 1ns/1ps

// Summary of operation
// - Two identical instances, register sets based at 7400h and 7500h.
// - Each timer holds a 16-bit up/down counter, readable and writable.
// - Timer compare and period go through shadows, loaded when counter is zero.
// - Each timer flags underflow, overflow, compare and period, each maskable.
// - Timer clock is internal or external pin, then a programmable prescaler.
// - Directional mode counts up or down by the direction pin level.
// - Continuous up, continuous up/down and directional modes; timers may run synchronised.
// - Timer 1 times the compare units; timer 1 or 2 times capture; quadrature counts timer 2 only.
// - Three compare units on timer 1 drive six outputs with shadowed compares.
// - Three 8-bit deadband counters share one 8-bit deadband value.
// - Each compare unit yields a complementary pair, deadband enabled per unit.
// - Compare-unit output polarity and forcing come from a shadowed action control register; timer outputs have none.
// - Eight PWM outputs: three deadband pairs plus two timer compare outputs.
// - Smallest non-zero deadband is at least 25 ns.
// - Qualified protect pin low tri-states all PWM pins; level reads at bit 8.
// - Selected capture edge stores the chosen timer count in a two-deep FIFO.
// - Capture inputs are synchronised; source holds a level over two clock edges. The qualifier here needs 6 or 12 steady edges.
// - Capture edge select: rising, falling or both.
// - Software picks timer 1 or timer 2 as capture time base.
// - Each capture channel sets its own maskable flag.
// - Quadrature mode counts timer 2 on every edge of both inputs, by direction.
// - Qualified inputs change after 6 or 12 steady edges; control bit 6 picks 12.
module mevm_event_manager
  import mevm_pkg::*;
#(
  parameter logic [15:0] BASE_ADDR = mevm_pkg::EVENT_MGR_A_BASE
)(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire mevm_pkg::mevm_pins_t pins,
  output mevm_pkg::mevm_pwm_t      pwm,
  output logic [1:0]               external_interrupt_qual,
  output logic                     conversion_start_qual,
  output logic                     event_irq
);
  import mevm_pkg::*;

  mevm_state_t      s;
  mevm_state_t      n;
  logic [1:0]       tick;
  logic [15:0]      fset;
  logic [15:0]      fclr;
  logic [2:0]       raw;
  logic [2:0]       cap_hit;
  logic [2:0]       cap_pop;
  logic [2:0][15:0] cap_val;
  logic             qep_chg;
  logic             qep_up;
  logic             ext_rise;
  logic             apb_wr;
  logic             apb_setup;
  logic             ten;
  logic             qepm;
  logic             src;
  logic             up;
  logic             hold;
  logic [6:0]       pmask;
  logic [3:0]       qlim;
  logic [7:0]       off;
  logic [1:0]       esel;
  mevm_tmode_t      mode;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mapped word inside this instance's window
  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a[31:16] == 16'h0000) && (a[15:8] == BASE_ADDR[15:8]) && (a[1:0] == 2'b00)
              && (a[7:0] <= OFF_SYSTEM_CONTROL_REG2);
  endfunction

  // Polarity and forcing of one output
  function automatic logic apply_action(input logic [1:0] act, input logic v);
    case (act)
      2'b00:   apply_action = 1'b0;
      2'b01:   apply_action = ~v;
      2'b10:   apply_action = v;
      default: apply_action = 1'b1;
    endcase
  endfunction

  // Register read mux
  function automatic logic [15:0] read_word(input mevm_state_t st, input logic [7:0] o);
    logic t;
    t = o[4];
    if (o < OFF_COMCON && o[3:0] == OFF_CNT[3:0])
      read_word = st.cnt[t];
    else if (o < OFF_COMCON && o[3:0] == OFF_CMP[3:0])
      read_word = st.cmp_sh[t];
    else if (o < OFF_COMCON && o[3:0] == OFF_PRD[3:0])
      read_word = st.prd_sh[t];
    else if (o < OFF_COMCON)
      read_word = st.con[t];
    else if (o == OFF_COMCON)
      read_word = {st.comcon[15:9], st.qual[QUAL_PDP_IDX], st.comcon[7:0]};
    else if (o == OFF_ACTION_CONTROL_REG)
      read_word = st.action_control_reg_sh;
    else if (o == OFF_DBAND)
      read_word = {8'h00, st.dband};
    else if (o == OFF_FCMP1)
      read_word = st.fcmp_sh[0];
    else if (o == OFF_FCMP1 + OFF_STEP)
      read_word = st.fcmp_sh[1];
    else if (o == OFF_FCMP1 + 2 * OFF_STEP)
      read_word = st.fcmp_sh[2];
    else if (o == OFF_CAPCON)
      read_word = st.capcon;
    else if (o == OFF_CAPFIFO)
      read_word = {10'h000, st.fcount[2], st.fcount[1], st.fcount[0]};
    else if (o == OFF_CAPDATA1)
      read_word = st.fifo[0][0];
    else if (o == OFF_CAPDATA1 + OFF_STEP)
      read_word = st.fifo[1][0];
    else if (o == OFF_CAPDATA1 + 2 * OFF_STEP)
      read_word = st.fifo[2][0];
    else if (o == OFF_FLAGS)
      read_word = st.flags;
    else if (o == OFF_MASK)
      read_word = st.mask;
    else
      read_word = {9'h000, st.qual_long, 6'h00};
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    n         = s;
    tick      = 2'b00;
    fset      = 16'h0000;
    fclr      = 16'h0000;
    raw       = 3'b000;
    cap_hit   = 3'b000;
    cap_pop   = 3'b000;
    cap_val   = '0;
    ten       = 1'b0;
    qepm      = 1'b0;
    src       = 1'b0;
    up        = 1'b1;
    hold      = 1'b0;
    pmask     = 7'h00;
    esel      = 2'b00;
    mode      = TM_STOP;
    off       = paddr[7:0];
    apb_setup = psel && !penable;
    apb_wr    = psel && penable && pwrite && addr_ok(paddr);

    // Two-stage synchroniser then glitch qualifier
    n.sync1 = {pins.conversion_start_pin, pins.external_interrupt_pins,
               pins.power_protect_pin, pins.capture_input_pin};
    n.sync2 = s.sync1;
    qlim    = s.qual_long ? (QUAL_LONG - 4'h1) : (QUAL_SHORT - 4'h1);
    for (int k = 0; k < 7; k++)
    begin
      if (s.sync2[k] == s.qual[k])
        n.qcnt[k] = 4'h0;
      else if (s.qcnt[k] >= qlim)
      begin
        n.qual[k] = s.sync2[k];
        n.qcnt[k] = 4'h0;
      end
      else
        n.qcnt[k] = s.qcnt[k] + 4'h1;
    end
    n.cap_prev = s.qual[2:0];

    // Quadrature decode on qualified inputs 1 and 2
    qep_chg  = (s.qual[0] ^ s.cap_prev[0]) || (s.qual[1] ^ s.cap_prev[1]);
    qep_up   = s.qual[0] ^ s.cap_prev[1];
    ext_rise = pins.external_timer_clock_pin && !s.ext_prev;
    n.ext_prev = pins.external_timer_clock_pin;

    // General-purpose timers
    for (int i = 0; i < 2; i++)
    begin
      ten   = s.con[i][TCON_ENABLE_BIT];
      qepm  = (i == 1) && s.capcon[CAPCON_QEP_BIT];
      pmask = 7'((8'h01 << s.con[i][TCON_PRESC_LSB +: 3]) - 8'h01);
      src   = s.con[i][TCON_EXTCLK_BIT] ? ext_rise : 1'b1;
      if (qepm)
        tick[i] = qep_chg;
      else if (i == 1 && s.con[1][TCON_SYNC_BIT])
        tick[i] = tick[0];
      else if (ten && src)
      begin
        if (s.psc[i] >= pmask)
        begin
          n.psc[i] = 7'h00;
          tick[i]  = 1'b1;
        end
        else
          n.psc[i] = s.psc[i] + 7'h01;
      end
      mode = mevm_tmode_t'(s.con[i][TCON_MODE_LSB +: 2]);
      hold = 1'b0;
      if (qepm)
        up = qep_up;
      else
        case (mode)
          TM_UP:     up = 1'b1;
          TM_UPDOWN: up = s.down[i] ? (s.cnt[i] == 16'h0000) : (s.cnt[i] < s.prd[i]);
          TM_DIR:    up = pins.count_direction_pin;
          default:
          begin
            up   = 1'b1;
            hold = 1'b1;
          end
        endcase
      if (tick[i] && !hold)
      begin
        fset[4*i+3] = (s.cnt[i] == s.prd[i]);
        fset[4*i+2] = (s.cnt[i] == s.cmp[i]);
        fset[4*i+1] = up && (s.cnt[i] == 16'hffff);
        fset[4*i]   = (s.cnt[i] == 16'h0000) && (!up || s.down[i]);
        if (!qepm && mode == TM_UP && s.cnt[i] >= s.prd[i])
          n.cnt[i] = 16'h0000;
        else
          n.cnt[i] = up ? s.cnt[i] + 16'h0001 : s.cnt[i] - 16'h0001;
        if (!qepm && mode == TM_UPDOWN)
          n.down[i] = !up;
      end
      // Shadow reload at counter zero
      if (s.cnt[i] == 16'h0000)
      begin
        n.cmp[i] = s.cmp_sh[i];
        n.prd[i] = s.prd_sh[i];
      end
      n.t_level[i] = ten && (s.cnt[i] >= s.cmp[i]);
    end

    // Full compare and deadband, timed by timer 1
    if (s.cnt[0] == 16'h0000)
    begin
      n.fcmp = s.fcmp_sh;
      n.action_control_reg = s.action_control_reg_sh;
    end
    for (int k = 0; k < 3; k++)
    begin
      raw[k] = s.comcon[COMCON_EN_BIT] && (s.cnt[0] >= s.fcmp[k]);
      if (raw[k] != s.raw_prev[k])
      begin
        if (s.comcon[COMCON_DB_LSB + k] && s.dband != 8'h00)
          n.db_cnt[k] = (s.dband < DB_MIN_CYC) ? DB_MIN_CYC : s.dband;
        else
          n.db_cnt[k] = 8'h00;
      end
      else if (s.db_cnt[k] != 8'h00)
        n.db_cnt[k] = s.db_cnt[k] - 8'h01;
      n.raw_prev[k]       = raw[k];
      n.pwm_level[2*k]    = apply_action(s.action_control_reg[4*k +: 2], raw[k] && n.db_cnt[k] == 8'h00);
      n.pwm_level[2*k+1]  = apply_action(s.action_control_reg[4*k+2 +: 2], !raw[k] && n.db_cnt[k] == 8'h00);
    end

    // Capture channels with two-deep FIFOs
    for (int c = 0; c < 3; c++)
    begin
      esel       = s.capcon[2*c +: 2];
      cap_hit[c] = s.capcon[CAPCON_EN_LSB + c] && !(c < 2 && s.capcon[CAPCON_QEP_BIT])
                   && ((s.qual[c] && !s.cap_prev[c] && esel[0])
                   || (!s.qual[c] && s.cap_prev[c] && esel[1]));
      cap_val[c] = s.capcon[CAPCON_TSEL_BIT] ? s.cnt[0] : s.cnt[1];
      cap_pop[c] = psel && penable && !pwrite && (off == OFF_CAPDATA1 + 8'(c) * OFF_STEP)
                   && addr_ok(paddr);
      if (cap_pop[c] && s.fcount[c] != 2'd0)
      begin
        n.fifo[c][0] = s.fifo[c][1];
        n.fcount[c]  = s.fcount[c] - 2'd1;
      end
      if (cap_hit[c])
      begin
        if (n.fcount[c] == 2'd2)
        begin
          n.fifo[c][0] = n.fifo[c][1];
          n.fifo[c][1] = cap_val[c];
        end
        else
        begin
          n.fifo[c][n.fcount[c][0]] = cap_val[c];
          n.fcount[c] = n.fcount[c] + 2'd1;
        end
        fset[FLAG_CAP_LSB + c] = 1'b1;
      end
    end

    // Register writes, after hardware updates so software wins
    if (apb_wr)
    begin
      if (off < OFF_COMCON && off[3:0] == OFF_CNT[3:0])
        n.cnt[off[4]] = pwdata[15:0];
      else if (off < OFF_COMCON && off[3:0] == OFF_CMP[3:0])
        n.cmp_sh[off[4]] = pwdata[15:0];
      else if (off < OFF_COMCON && off[3:0] == OFF_PRD[3:0])
        n.prd_sh[off[4]] = pwdata[15:0];
      else if (off < OFF_COMCON)
        n.con[off[4]] = pwdata[15:0];
      else if (off == OFF_COMCON)
        n.comcon = pwdata[15:0];
      else if (off == OFF_ACTION_CONTROL_REG)
        n.action_control_reg_sh = pwdata[15:0];
      else if (off == OFF_DBAND)
        n.dband = pwdata[7:0];
      else if (off == OFF_FCMP1)
        n.fcmp_sh[0] = pwdata[15:0];
      else if (off == OFF_FCMP1 + OFF_STEP)
        n.fcmp_sh[1] = pwdata[15:0];
      else if (off == OFF_FCMP1 + 2 * OFF_STEP)
        n.fcmp_sh[2] = pwdata[15:0];
      else if (off == OFF_CAPCON)
        n.capcon = pwdata[15:0];
      else if (off == OFF_FLAGS)
        fclr = pwdata[15:0];
      else if (off == OFF_MASK)
        n.mask = pwdata[15:0];
      else if (off == OFF_SYSTEM_CONTROL_REG2)
        n.qual_long = pwdata[SYSTEM_CONTROL_REG2_QUAL_BIT];
    end
    // Sticky flags, set beats write-one clear
    n.flags = (s.flags & ~fclr) | fset;

    // Read data latched in the setup cycle
    if (apb_setup)
      n.prdata = (!pwrite && addr_ok(paddr)) ? {16'h0000, read_word(s, off)} : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= MEVM_STATE_RESET;
    else
      s <= n;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pins released while protect input is qualified low
  assign pwm.cmp_level            = s.pwm_level;
  assign pwm.cmp_oe               = {6{s.qual[QUAL_PDP_IDX]}};
  assign pwm.timer_pwm_output     = s.t_level;
  assign pwm.timer_oe             = {2{s.qual[QUAL_PDP_IDX]}};
  assign external_interrupt_qual  = s.qual[5:4];
  assign conversion_start_qual    = s.qual[6];
  assign event_irq                = |(s.flags & s.mask);
  assign prdata                   = s.prdata;
  assign pready                   = 1'b1;
  assign pslverr                  = psel && penable && !addr_ok(paddr);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pdp_low_held;
    (!s.qual_long && !s.sync2[QUAL_PDP_IDX] && !s.qual[QUAL_PDP_IDX])[*6];
  endsequence

  sequence s_cap_full_push;
    cap_hit[0] && !cap_pop[0] && s.fcount[0] == 2'd2;
  endsequence

  a_pdp_tristate: assert property (s_pdp_low_held |=> pwm.cmp_oe == 6'h00 && pwm.timer_oe == 2'h0)
    else $error("PWM pins driven while protect input held low");
  a_qual_steady: assert property ($changed(s.qual[0]) |->
      $past(s.qcnt[0]) == ($past(s.qual_long) ? QUAL_LONG - 4'h1 : QUAL_SHORT - 4'h1))
    else $error("Qualified level changed before steady count");
  a_sync_source: assert property ($changed(s.qual[1]) |-> $past(s.sync2[1]) == s.qual[1])
    else $error("Qualified level not taken from synchroniser");
  a_cap_overwrite: assert property (s_cap_full_push |=> s.fcount[0] == 2'd2 && s.fifo[0][1] == $past(cap_val[0]))
    else $error("Full capture FIFO did not keep newest value");
  a_cap_flag_set: assert property (cap_hit[0] |=> s.flags[FLAG_CAP_LSB])
    else $error("Capture flag not set on capture");
  a_flag_set_wins: assert property (fset[0] && apb_wr && paddr[7:0] == OFF_FLAGS && pwdata[0] |=> s.flags[0])
    else $error("Underflow flag lost to simultaneous clear");
  a_up_wrap: assert property (tick[0] && s.con[0][1:0] == TM_UP && s.cnt[0] >= s.prd[0] && !apb_wr
      |=> s.cnt[0] == 16'h0000)
    else $error("Up counter did not wrap at period");
  a_shadow_load: assert property (s.cnt[0] == 16'h0000 && !apb_wr |=> s.prd[0] == $past(s.prd_sh[0]))
    else $error("Period shadow not loaded at zero");
  a_dband_min: assert property (raw[0] != s.raw_prev[0] && s.comcon[COMCON_DB_LSB] && s.dband != 8'h00
      |=> s.db_cnt[0] >= DB_MIN_CYC && !s.pwm_level[0] && !s.pwm_level[1] || s.action_control_reg[3:0] != 4'ha)
    else $error("Deadband gap shorter than minimum");
  a_qep_count_up: assert property (s.capcon[CAPCON_QEP_BIT] && qep_chg && qep_up && !apb_wr
      |=> s.cnt[1] == $past(s.cnt[1]) + 16'h0001)
    else $error("Quadrature edge did not count timer 2 up");
  a_counter_read: assert property (psel && !penable && !pwrite && paddr == {16'h0000, BASE_ADDR}
      |=> s.prdata[15:0] == $past(s.cnt[0]))
    else $error("Counter read returned wrong value");

endmodule

// ===== mevm_far_side.sv
`timescale 1ns/1ps
// Far side: protect pin, capture pin 1 and encoder on capture pins 1 and 2
module mevm_far_side
  import mevm_pkg::*;
(
  input  wire logic            pclk,
  output mevm_pkg::mevm_pins_t pins
);
  initial pins = '0;
  // Protect level, changed just after an edge
  task automatic prot(input logic v);
    @(posedge pclk);
    pins.power_protect_pin <= v;
  endtask
  // High for n cycles, then low for n cycles
  task automatic cap(input int n);
    @(posedge pclk);
    pins.capture_input_pin[0] <= 1'b1;
    repeat (n) @(posedge pclk);
    pins.capture_input_pin[0] <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  // One encoder cycle, input 1 leading input 2, each step held n+1 cycles
  task automatic quad(input int n);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge pclk);
      pins.capture_input_pin[1:0] <= {k[0] ^ k[1], ~k[1]};
      repeat (n) @(posedge pclk);
    end
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import mevm_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic        pready, pslverr, er, irq;
  mevm_pins_t  pins;
  mevm_pwm_t   pwm;
  int          bad_count = 0, cmp_count = 0;
  // Clock generator
  always #10 pclk = ~pclk;
  mevm_event_manager dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .pwm(pwm), .external_interrupt_qual(),
    .conversion_start_qual(), .event_irq(irq));
  mevm_far_side far_u (.pclk(pclk), .pins(pins));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, s, e);
    end
  endtask
  // One APB transfer; read data and error land in rd, er
  task automatic apb(input logic w, input logic [7:0] off, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {16'h0, EVENT_MGR_A_BASE[15:8], off};
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      tally_and_finish;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, OFF_CNT, 16'h1234);
    apb(1'b0, OFF_CNT, 16'h0);
    chk(rd, 33'h1234);
    apb(1'b0, 8'h58, 16'h0);
    chk({er, rd}, {1'b1, 32'h0});
    // Protect pin releases and then tri-states the outputs
    far_u.prot(1'b1);
    repeat (12) @(posedge pclk);
    apb(1'b0, OFF_COMCON, 16'h0);
    chk(rd[8], 33'h1);
    chk({pwm.cmp_oe, pwm.timer_oe}, 33'hff);
    far_u.prot(1'b0);
    repeat (12) @(posedge pclk);
    chk({pwm.cmp_oe, pwm.timer_oe}, 33'h0);
    // Three rising captures into a two-deep FIFO
    apb(1'b1, OFF_CAPCON, 16'h0141);
    apb(1'b1, OFF_MASK, 16'h0100);
    for (int i = 1; i < 4; i++)
    begin
      apb(1'b1, OFF_CNT, 16'(i));
      far_u.cap(10);
    end
    chk(irq, 33'h1);
    apb(1'b0, OFF_CAPFIFO, 16'h0);
    chk(rd[1:0], 33'h2);
    apb(1'b0, OFF_CAPDATA1, 16'h0);
    chk(rd, 33'h2);
    apb(1'b0, OFF_CAPDATA1, 16'h0);
    chk(rd, 33'h3);
    // Long qualifier swallows an 8-cycle pulse
    apb(1'b1, OFF_FLAGS, 16'h0100);
    apb(1'b1, OFF_SYSTEM_CONTROL_REG2, 16'h0040);
    far_u.cap(8);
    chk(irq, 33'h0);
    apb(1'b0, OFF_CAPFIFO, 16'h0);
    chk(rd[1:0], 33'h0);
    // Falling edge only, timer 1 counting up from zero
    apb(1'b1, OFF_SYSTEM_CONTROL_REG2, 16'h0);
    apb(1'b1, OFF_CAPCON, 16'h0142);
    apb(1'b1, OFF_PRD, 16'hffff);
    apb(1'b1, OFF_CNT, 16'h0);
    apb(1'b1, OFF_CON, 16'h0005);
    far_u.cap(10);
    apb(1'b0, OFF_CAPFIFO, 16'h0);
    chk(rd[1:0], 33'h1);
    apb(1'b0, OFF_CAPDATA1, 16'h0);
    chk(rd, 33'h13);
    // One encoder cycle counts timer 2 four times
    apb(1'b1, OFF_CAPCON, 16'h0080);
    far_u.quad(12);
    apb(1'b0, OFF_TIMER2, 16'h0);
    chk(rd, 33'h4);
    // Deadband pair and timer output around compare value 40h
    apb(1'b1, OFF_FCMP1, 16'h0040);
    apb(1'b1, OFF_CMP, 16'h0040);
    apb(1'b1, OFF_ACTION_CONTROL_REG, 16'h000a);
    apb(1'b1, OFF_DBAND, 16'h0001);
    apb(1'b1, OFF_COMCON, 16'h0003);
    apb(1'b1, OFF_CNT, 16'h0);
    repeat (20) @(posedge pclk);
    chk({pwm.timer_pwm_output[0], pwm.cmp_level[1:0]}, 33'h2);
    repeat (100) @(posedge pclk);
    chk({pwm.timer_pwm_output[0], pwm.cmp_level[1:0]}, 33'h5);
    tally_and_finish;
  end
endmodule
